// ### shared/lwdc_consts.svh
`ifndef LWDC_CONSTS_SVH
`define LWDC_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define LWDC_IDX_MOWC   6'h10
`define LWDC_IDX_DEPTH  6'h11
`define LWDC_IDX_DCFG   6'h12
`define LWDC_IDX_SCAN   6'h13
`define LWDC_IDX_STAT   6'h20

// Reset values.
`define LWDC_RST_MOWC   8'h04
`define LWDC_RST_DEPTH  8'h05
`define LWDC_RST_DCFG   8'h00
`define LWDC_RST_SCAN   8'h03

// Writable bit masks; other bits read as zero.
`define LWDC_WM_MOWC    8'hdf
`define LWDC_WM_DEPTH   8'h0f
`define LWDC_WM_DCFG    8'hff
`define LWDC_WM_SCAN    8'h07

// Field positions.
`define LWDC_B_OV1EN    7
`define LWDC_B_OV2EN    6
`define LWDC_B_PSEL     4
`define LWDC_B_MDEP     2
`define LWDC_B_DEONLY   0
`define LWDC_B_OV1DEP   2
`define LWDC_B_OV2DEP   0
`define LWDC_B_CLKINV   7
`define LWDC_B_DISPON   6
`define LWDC_B_CBAR     5
`define LWDC_B_VREV     3
`define LWDC_B_ORDER    0
`define LWDC_B_PDIDLE   2
`define LWDC_B_HSIDLE   1
`define LWDC_B_VSIDLE   0

// Panel timing in panel clocks.
`define LWDC_H_ACT      8'd32
`define LWDC_H_SYNC0    8'd36
`define LWDC_H_SYNC1    8'd40
`define LWDC_H_TOT      8'd48
`define LWDC_V_ACT      8'd16
`define LWDC_V_SYNC0    8'd17
`define LWDC_V_SYNC1    8'd18
`define LWDC_V_TOT      8'd20

// Output order codes.
`define LWDC_ORD_GRAY   3'h6
`define LWDC_ORD_IDLE   3'h7

`endif

// ### shared/lwdc_pkg.sv
package lwdc_pkg;

	// Decoded colour depth.
	typedef enum logic [1:0] {
		LWDC_D8  = 2'h0,
		LWDC_D16 = 2'h1,
		LWDC_D24 = 2'h2
	} lwdc_depth_e;

	// Configuration crossing handshake states.
	typedef enum logic [1:0] {
		LWDC_CX_IDLE = 2'h1,
		LWDC_CX_BUSY = 2'h2
	} lwdc_cx_e;

	// Source of the pixel being launched.
	typedef enum logic [2:0] {
		LWDC_SRC_MAIN = 3'h0,
		LWDC_SRC_OV1  = 3'h1,
		LWDC_SRC_OV2  = 3'h2,
		LWDC_SRC_BAR  = 3'h3,
		LWDC_SRC_IDLE = 3'h4
	} lwdc_src_e;

	// Settings used by the pixel side.
	typedef struct packed {
		logic       ov1En;
		logic       ov2En;
		logic       deOnly;
		logic       clkInv;
		logic       dispOn;
		logic       colorBar;
		logic       vRev;
		logic [2:0] order;
		logic       pdIdle;
		logic       hsIdle;
		logic       vsIdle;
	} lwdc_cfg_s;

	// One overlay layer: colour and coverage of the current pixel.
	typedef struct packed {
		logic [23:0] rgb;
		logic        hit;
	} lwdc_layer_s;

endpackage

// ### rtl/lwdc_top.sv
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "lwdc_consts.svh"

// How it works
// - First overlay shown only when enabled.
// - Second overlay shown only when enabled.
// - First overlay always drawn above second.
// - Select bit routes window parameter accesses.
// - Main depth: 00=8, 01=16, 1x=24 bpp.
// - First overlay depth from bits 3..2.
// - Second overlay depth from bits 1..0.
// - DE-only mode parks both syncs idle.
// - Inversion bit picks panel sampling edge.
// - Panel output only while display on.
// - Colour bar replaces image when set.
// - Vertical bit reverses line scan order.
// - Reverse scan suppresses overlays and cursors.
// - Order codes 0..5 permute colour components.
// - Gray code and idle code on bus.
// - Pixel bus idle level in blanking/off.
// - Sync idle levels, both default high.
module lwdc_top
	import lwdc_pkg::*;
(
	// Core clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Core-side status.
	output lwdc_depth_e      mainDepth,
	output lwdc_depth_e      ov1Depth,
	output lwdc_depth_e      ov2Depth,
	output logic             paramSel,
	// Pixel clock and layer inputs.
	input  wire logic        pixClk,
	input  wire logic [23:0] mainRgb,
	input  lwdc_layer_s      win1,
	input  lwdc_layer_s      win2,
	// Panel side.
	output logic             pnlClk,
	output logic             pnlHsync,
	output logic             pnlVsync,
	output logic             pnlDe,
	output logic      [23:0] panel_pixel_bus,
	output logic      [7:0]  scanLine,
	output logic             cursorEn
);

	// Colour depth decode shared by the three depth fields.
	function automatic lwdc_depth_e decodeDepth(input logic [1:0] f);
		lwdc_depth_e d;
		d = LWDC_D24;
		if (!f[1]) begin
			d = f[0] ? LWDC_D16 : LWDC_D8;
		end
		return d;
	endfunction

	// Colour component arrangement on the panel bus.
	function automatic logic [23:0] reorder(input logic [2:0] o,
		input logic [23:0] c);
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		logic [9:0] y;
		r = c[23:16];
		g = c[15:8];
		b = c[7:0];
		y = 10'({2'h0, r} + {1'h0, g, 1'h0} + {2'h0, b});
		unique case (o)
			3'h0: reorder = {r, g, b};
			3'h1: reorder = {r, b, g};
			3'h2: reorder = {g, r, b};
			3'h3: reorder = {g, b, r};
			3'h4: reorder = {b, r, g};
			3'h5: reorder = {b, g, r};
			default: reorder = {y[9:2], y[9:2], y[9:2]};
		endcase
	endfunction

	// Register file.
	logic [7:0] mowc_r;
	logic [7:0] depth_r;
	logic [7:0] dcfg_r;
	logic [7:0] scan_r;
	logic       ack_r;
	logic [31:0] rdat_r;
	logic       busReq;
	logic       busWr;
	logic [5:0] idx;
	logic [7:0] wdat;
	logic [7:0] rdSel;
	logic       vbSync1_r;
	logic       vbSync2_r;
	logic       pend;
	logic       pnlVblank_r;

	assign busReq = wb_cyc_i & wb_stb_i;
	assign idx    = wb_adr_i[7:2];
	// Writes land on the edge at which the master sees ack.
	assign busWr  = busReq & ack_r & wb_we_i & wb_sel_i[0];
	assign wdat   = wb_dat_i[7:0];

	// Acknowledge one cycle after the request, then drop.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= busReq & ~ack_r;
		end
	end

	// Register writes; reserved bits are masked off.
	// stored fields.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mowc_r  <= `LWDC_RST_MOWC;
			depth_r <= `LWDC_RST_DEPTH;
			dcfg_r  <= `LWDC_RST_DCFG;
			scan_r  <= `LWDC_RST_SCAN;
		end else if (busWr) begin
			if (idx == `LWDC_IDX_MOWC) begin
				mowc_r <= wdat & `LWDC_WM_MOWC;
			end
			if (idx == `LWDC_IDX_DEPTH) begin
				depth_r <= wdat & `LWDC_WM_DEPTH;
			end
			if (idx == `LWDC_IDX_DCFG) begin
				dcfg_r <= wdat & `LWDC_WM_DCFG;
			end
			if (idx == `LWDC_IDX_SCAN) begin
				scan_r <= wdat & `LWDC_WM_SCAN;
			end
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rdSel = 8'h00;
		unique case (idx)
			`LWDC_IDX_MOWC:  rdSel = mowc_r;
			`LWDC_IDX_DEPTH: rdSel = depth_r;
			`LWDC_IDX_DCFG:  rdSel = dcfg_r;
			`LWDC_IDX_SCAN:  rdSel = scan_r;
			`LWDC_IDX_STAT:  rdSel = {6'h00, pend, vbSync2_r};
			default:         rdSel = 8'h00;
		endcase
	end

	// Read data is registered together with ack.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdat_r <= 32'h0000_0000;
		end else if (busReq & ~ack_r) begin
			rdat_r <= {24'h00_0000, rdSel};
		end
	end

	// Decoded depths and the parameter select for the window registers.
	// depth decode.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mainDepth <= LWDC_D16;
			ov1Depth  <= LWDC_D16;
			ov2Depth  <= LWDC_D16;
			paramSel  <= 1'b0;
		end else begin
			mainDepth <= decodeDepth(mowc_r[`LWDC_B_MDEP +: 2]);
			ov1Depth  <= decodeDepth(depth_r[`LWDC_B_OV1DEP +: 2]);
			ov2Depth  <= decodeDepth(depth_r[`LWDC_B_OV2DEP +: 2]);
			paramSel  <= mowc_r[`LWDC_B_PSEL];
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// Settings bundle gathered from the registers.
	lwdc_cfg_s live;
	assign live = '{
		ov1En:    mowc_r[`LWDC_B_OV1EN],
		ov2En:    mowc_r[`LWDC_B_OV2EN],
		deOnly:   mowc_r[`LWDC_B_DEONLY],
		clkInv:   dcfg_r[`LWDC_B_CLKINV],
		dispOn:   dcfg_r[`LWDC_B_DISPON],
		colorBar: dcfg_r[`LWDC_B_CBAR],
		vRev:     dcfg_r[`LWDC_B_VREV],
		order:    dcfg_r[`LWDC_B_ORDER +: 3],
		pdIdle:   scan_r[`LWDC_B_PDIDLE],
		hsIdle:   scan_r[`LWDC_B_HSIDLE],
		vsIdle:   scan_r[`LWDC_B_VSIDLE]
	};

	// Toggle handshake carrying the settings word to the pixel side.
	lwdc_cx_e   cx_r;
	lwdc_cfg_s  hold_r;
	logic       reqTog_r;
	logic       ackSync1_r;
	logic       ackSync2_r;
	logic       ackTog_r;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cx_r     <= LWDC_CX_IDLE;
			hold_r   <= '0;
			reqTog_r <= 1'b0;
		end else begin
			unique case (cx_r)
				LWDC_CX_IDLE: begin
					if (live != hold_r) begin
						hold_r   <= live;
						reqTog_r <= ~reqTog_r;
						cx_r     <= LWDC_CX_BUSY;
					end
				end
				LWDC_CX_BUSY: begin
					if (ackSync2_r == reqTog_r) begin
						cx_r <= LWDC_CX_IDLE;
					end
				end
			endcase
		end
	end

	assign pend = (cx_r == LWDC_CX_BUSY) | (live != hold_r);

	// Return path of the handshake and the blanking status.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ackSync1_r <= 1'b0;
			ackSync2_r <= 1'b0;
			vbSync1_r  <= 1'b0;
			vbSync2_r  <= 1'b0;
		end else begin
			ackSync1_r <= ackTog_r;
			ackSync2_r <= ackSync1_r;
			vbSync1_r  <= pnlVblank_r;
			vbSync2_r  <= vbSync1_r;
		end
	end

	// Pixel clock domain.
	logic       pRst1_r;
	logic       pRst2_r;
	logic       reqSync1_r;
	logic       reqSync2_r;
	logic       reqSync3_r;
	lwdc_cfg_s  cur_r;
	logic       phase_r;
	logic [7:0] hCnt_r;
	logic [7:0] vCnt_r;
	logic       invL_r;
	lwdc_src_e  src_r;
	logic       launch;
	logic       hAct;
	logic       vAct;
	logic [2:0] bar;
	lwdc_src_e  srcNxt;
	logic [23:0] colNxt;

	// Reset and request synchronisers into the pixel domain.
	always_ff @(posedge pixClk) begin
		pRst1_r <= sys_rst;
		pRst2_r <= pRst1_r;
	end

	// Load the settings word when the request toggle moves.
	always_ff @(posedge pixClk) begin
		if (pRst2_r) begin
			reqSync1_r <= 1'b0;
			reqSync2_r <= 1'b0;
			reqSync3_r <= 1'b0;
			ackTog_r   <= 1'b0;
			cur_r      <= '0;
		end else begin
			reqSync1_r <= reqTog_r;
			reqSync2_r <= reqSync1_r;
			reqSync3_r <= reqSync2_r;
			if (reqSync2_r != reqSync3_r) begin
				cur_r    <= hold_r;
				ackTog_r <= reqSync2_r;
			end
		end
	end

	// Panel clock is the pixel clock halved; data launches on phase 0.
	assign launch = ~phase_r;
	assign hAct   = hCnt_r < `LWDC_H_ACT;
	assign vAct   = vCnt_r < `LWDC_V_ACT;
	assign bar    = hCnt_r[4:2];

	// Pixel and line counters.
	always_ff @(posedge pixClk) begin
		if (pRst2_r) begin
			phase_r     <= 1'b0;
			hCnt_r      <= 8'h00;
			vCnt_r      <= 8'h00;
			pnlVblank_r <= 1'b0;
		end else begin
			phase_r <= ~phase_r;
			if (launch) begin
				if (hCnt_r == `LWDC_H_TOT - 8'd1) begin
					hCnt_r <= 8'h00;
					if (vCnt_r == `LWDC_V_TOT - 8'd1) begin
						vCnt_r <= 8'h00;
					end else begin
						vCnt_r <= vCnt_r + 8'd1;
					end
				end else begin
					hCnt_r <= hCnt_r + 8'd1;
				end
				pnlVblank_r <= ~vAct;
			end
		end
	end

	// Layer selection for the pixel being launched.
	always_comb begin
		srcNxt = LWDC_SRC_MAIN;
		colNxt = mainRgb;
		if (!cur_r.dispOn || !hAct || !vAct ||
			cur_r.order == `LWDC_ORD_IDLE) begin
			srcNxt = LWDC_SRC_IDLE;
			colNxt = {24{cur_r.pdIdle}};
		end else if (cur_r.colorBar) begin
			srcNxt = LWDC_SRC_BAR;
			colNxt = {{8{bar[2]}}, {8{bar[1]}}, {8{bar[0]}}};
		end else if (cur_r.ov1En && win1.hit && !cur_r.vRev) begin
			srcNxt = LWDC_SRC_OV1;
			colNxt = win1.rgb;
		end else if (cur_r.ov2En && win2.hit && !cur_r.vRev) begin
			srcNxt = LWDC_SRC_OV2;
			colNxt = win2.rgb;
		end
	end

	// Panel outputs, all launched on the panel clock edge chosen.
	always_ff @(posedge pixClk) begin
		if (pRst2_r) begin
			pnlClk          <= 1'b0;
			pnlHsync        <= 1'b1;
			pnlVsync        <= 1'b1;
			pnlDe           <= 1'b0;
			panel_pixel_bus <= 24'h00_0000;
			scanLine        <= 8'h00;
			cursorEn        <= 1'b1;
			src_r           <= LWDC_SRC_IDLE;
			invL_r          <= 1'b0;
		end else begin
			// launch edge.
			// The second half reuses the launch polarity, so a setting
			// that lands mid-period cannot swallow the sampling edge.
			pnlClk <= launch ? cur_r.clkInv : ~invL_r;
			if (launch) begin
				invL_r <= cur_r.clkInv;
				src_r <= srcNxt;
				pnlDe <= cur_r.dispOn & hAct & vAct;
				if (!cur_r.dispOn || cur_r.deOnly) begin
					pnlHsync <= cur_r.hsIdle;
					pnlVsync <= cur_r.vsIdle;
				end else begin
					pnlHsync <= ~(hCnt_r >= `LWDC_H_SYNC0 &&
						hCnt_r < `LWDC_H_SYNC1);
					pnlVsync <= ~(vCnt_r >= `LWDC_V_SYNC0 &&
						vCnt_r < `LWDC_V_SYNC1);
				end
				panel_pixel_bus <= (srcNxt == LWDC_SRC_IDLE) ? colNxt :
					reorder(cur_r.order, colNxt);
				scanLine <= cur_r.vRev ?
					8'(`LWDC_V_ACT - 8'd1 - vCnt_r) : vCnt_r;
				cursorEn <= ~cur_r.vRev;
			end
		end
	end

	// Checks in the core domain.
	// select follows write.
	property p_psel;
		@(posedge ref_clk) disable iff (sys_rst)
		busWr && idx == `LWDC_IDX_MOWC |=>
			##1 paramSel == $past(wdat[`LWDC_B_PSEL], 2);
	endproperty
	a_psel: assert property (p_psel) else $error("select wrong");

	property p_mdep;
		@(posedge ref_clk) disable iff (sys_rst)
		busWr && idx == `LWDC_IDX_MOWC && wdat[3] |=>
			##1 mainDepth == LWDC_D24;
	endproperty
	a_mdep: assert property (p_mdep) else $error("main depth");

	property p_d1;
		@(posedge ref_clk) disable iff (sys_rst)
		busWr && idx == `LWDC_IDX_DEPTH && wdat[3:2] == 2'h0 |=>
			##1 ov1Depth == LWDC_D8;
	endproperty
	a_d1: assert property (p_d1) else $error("ov1 depth");

	property p_d2;
		@(posedge ref_clk) disable iff (sys_rst)
		busWr && idx == `LWDC_IDX_DEPTH && wdat[1:0] == 2'h1 |=>
			##1 ov2Depth == LWDC_D16;
	endproperty
	a_d2: assert property (p_d2) else $error("ov2 depth");

	// Checks in the pixel domain.
	// first overlay gate.
	property p_ov1;
		@(posedge pixClk) disable iff (pRst2_r)
		launch && (!cur_r.ov1En || cur_r.vRev) |=>
			src_r != LWDC_SRC_OV1;
	endproperty
	a_ov1: assert property (p_ov1) else $error("ov1 shown");

	property p_ov2;
		@(posedge pixClk) disable iff (pRst2_r)
		launch && (!cur_r.ov2En || cur_r.vRev) |=>
			src_r != LWDC_SRC_OV2;
	endproperty
	a_ov2: assert property (p_ov2) else $error("ov2 shown");

	property p_stack;
		@(posedge pixClk) disable iff (pRst2_r)
		launch && srcNxt != LWDC_SRC_IDLE && !cur_r.colorBar &&
			cur_r.ov1En && win1.hit && !cur_r.vRev |=>
			src_r == LWDC_SRC_OV1;
	endproperty
	a_stack: assert property (p_stack) else $error("stack");

	property p_deonly;
		@(posedge pixClk) disable iff (pRst2_r)
		launch && cur_r.deOnly |=>
			pnlHsync == $past(cur_r.hsIdle) &&
			pnlVsync == $past(cur_r.vsIdle);
	endproperty
	a_deonly: assert property (p_deonly) else $error("sync");

	property p_edge;
		@(posedge pixClk) disable iff (pRst2_r)
		launch |=> pnlClk == $past(cur_r.clkInv) ##1
			pnlClk != $past(cur_r.clkInv, 2);
	endproperty
	a_edge: assert property (p_edge) else $error("clk edge");

	property p_off;
		@(posedge pixClk) disable iff (pRst2_r)
		launch && !cur_r.dispOn |=> !pnlDe &&
			panel_pixel_bus == {24{$past(cur_r.pdIdle)}};
	endproperty
	a_off: assert property (p_off) else $error("display off");

endmodule // lwdc_top

// ### dv/lwdc_panel_model.sv
`timescale 1ns/1ps

// Panel model: samples the pixel bus on the selected panel clock edge.
module lwdc_panel_model (
	// Panel pins.
	input  wire logic        pnlClk,
	input  wire logic        pnlHsync,
	input  wire logic        pnlDe,
	input  wire logic [23:0] pixBus,
	// Sampling edge select; high picks the falling edge.
	input  wire logic        sampleFall,
	// Observations for the bench.
	output int               pixCnt,
	output logic      [23:0] lastPix,
	output int               hsFalls,
	output int               holdErr
);
	logic [23:0] smp;
	time         lastChg;

	// Counters start clean.
	initial begin
		pixCnt = 0;
		hsFalls = 0;
		holdErr = 0;
		lastPix = 24'h000000;
		lastChg = 0;
	end

	// Time of the last data change, for the setup check.
	always @(pixBus) begin
		lastChg = $time;
	end

	// sampling edge check
	// Data must be settled before the sampling edge and held after it.
	always @(pnlClk) begin
		if (pnlClk !== sampleFall) begin
			smp = pixBus;
			if ($time - lastChg < 5) begin
				holdErr++;
			end
			if (pnlDe === 1'b1) begin
				pixCnt++;
				lastPix = pixBus;
			end
			#3;
			if (pixBus !== smp) begin
				holdErr++;
			end
		end
	end

	// sync pulses seen
	// Counts line sync pulses so the bench can tell the sync modes apart.
	always @(negedge pnlHsync) begin
		hsFalls++;
	end
endmodule // lwdc_panel_model

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "lwdc_consts.svh"

// Self-checking bench for the window and display control block.
module testbench;
	import lwdc_pkg::*;

	logic          ref_clk;
	logic          sys_rst;
	logic          pixClk;
	logic          wbCyc;
	logic          wbStb;
	logic          wbWe;
	logic    [7:0] wbAdr;
	logic    [3:0] wbSel;
	logic   [31:0] wbDatI;
	logic   [31:0] wbDatO;
	logic          wbAck;
	lwdc_depth_e   mainDepth;
	lwdc_depth_e   ov1Depth;
	lwdc_depth_e   ov2Depth;
	logic          paramSel;
	logic   [23:0] mainRgb;
	lwdc_layer_s   win1;
	lwdc_layer_s   win2;
	logic          pnlClk;
	logic          pnlHsync;
	logic          pnlVsync;
	logic          pnlDe;
	logic   [23:0] pixBus;
	logic    [7:0] scanLine;
	logic          cursorEn;
	logic          sampleFall;
	logic          jitter;
	logic   [23:0] lastPix;
	logic   [31:0] rd;
	int            errors;
	int            cmp_count;
	int            pixCnt;
	int            hsFalls;
	int            holdErr;
	int            h0;
	int            c0;
	int            v0;
	int            vsFalls = 0;
	int            j;

	// Core clock at 50 MHz and an unrelated 15 ns pixel clock.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		pixClk = 1'b0;
		#3.3;
		forever #7.5 pixClk = ~pixClk;
	end

	// Fresh image data every pixel clock while the edge test runs.
	always @(posedge pixClk) begin
		if (jitter) begin
			mainRgb <= 24'($urandom);
		end
	end

	// Frame sync pulses seen on the panel side.
	always @(negedge pnlVsync) begin
		vsFalls++;
	end

	lwdc_top dut_u (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.mainDepth(mainDepth), .ov1Depth(ov1Depth), .ov2Depth(ov2Depth),
		.paramSel(paramSel), .pixClk(pixClk), .mainRgb(mainRgb),
		.win1(win1), .win2(win2), .pnlClk(pnlClk), .pnlHsync(pnlHsync),
		.pnlVsync(pnlVsync), .pnlDe(pnlDe), .panel_pixel_bus(pixBus),
		.scanLine(scanLine), .cursorEn(cursorEn)
	);

	lwdc_panel_model panel_u (
		.pnlClk(pnlClk), .pnlHsync(pnlHsync), .pnlDe(pnlDe),
		.pixBus(pixBus), .sampleFall(sampleFall), .pixCnt(pixCnt),
		.lastPix(lastPix), .hsFalls(hsFalls), .holdErr(holdErr)
	);

	// Prints the verdict and ends the run.
	task automatic stop_test;
		if (errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle, held until ack is sampled high.
	task automatic wbXfer(input logic we, input logic [7:0] a,
			input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= 4'hf;
		wbDatI <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		q = wbDatO;
		if (n >= 50) begin
			chk(32'h0, 32'h1);
		end
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wbXfer(1'b1, a, d, rd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		wbXfer(1'b0, a, 8'h00, rd);
		chk(rd, exp);
	endtask

	// Lets settings cross, then waits for k fresh panel pixels.
	task automatic waitPix(input int k);
		int base;
		int n;
		repeat (30) @(posedge pixClk);
		base = pixCnt;
		n = 0;
		while (pixCnt < base + k && n < 4000) begin
			@(posedge pixClk);
			n++;
		end
		if (n >= 4000) begin
			chk(32'h0, 32'h1);
		end
	endtask

	// Depth field decode: upper bit set means 24 bits per pixel.
	function automatic lwdc_depth_e dec(input logic [1:0] x);
		return x[1] ? LWDC_D24 : (x[0] ? LWDC_D16 : LWDC_D8);
	endfunction

	// Expected bus word for an output order code.
	function automatic logic [23:0] perm(input logic [2:0] o,
			input logic [23:0] c, input logic idl);
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		logic [9:0] y;
		r = c[23:16];
		g = c[15:8];
		b = c[7:0];
		y = ({2'b00, r} + {1'b0, g, 1'b0} + {2'b00, b}) >> 2;
		case (o)
			3'h0: return {r, g, b};
			3'h1: return {r, b, g};
			3'h2: return {g, r, b};
			3'h3: return {g, b, r};
			3'h4: return {b, r, g};
			3'h5: return {b, g, r};
			3'h6: return {3{y[7:0]}};
			default: return {24{idl}};
		endcase
	endfunction

	// Main sequence.
	initial begin
		errors = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
		mainRgb = 24'h123456;
		win1 = '0;
		win2 = '0;
		sampleFall = 1'b0;
		jitter = 1'b0;
		void'($urandom(33896));
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdc(8'h40, 32'h04);
		rdc(8'h44, 32'h05);
		rdc(8'h48, 32'h00);
		rdc(8'h4c, 32'h03);
		rdc(8'h7c, 32'h00);
		chk(mainDepth, LWDC_D16);
		chk(ov1Depth, LWDC_D16);
		chk(ov2Depth, LWDC_D16);
		// Every depth code on the main and first overlay fields; random codes on the second.
		for (int i = 0; i < 4; i++) begin
			j = $urandom % 4;
			wr(8'h40, 8'(i << 2));
			wr(8'h44, {4'h0, 2'(i), 2'(j)});
			repeat (3) @(posedge ref_clk);
			chk(mainDepth, dec(2'(i)));
			chk(ov1Depth, dec(2'(i)));
			chk(ov2Depth, dec(2'(j)));
		end
		// Parameter select, with the read-only bit written high.
		wr(8'h40, 8'h3c);
		rdc(8'h40, 32'h1c);
		repeat (3) @(posedge ref_clk);
		chk(paramSel, 1'b1);
		// Display off: idle levels for every idle setting.
		wr(8'h48, 8'h00);
		for (int s = 0; s < 8; s++) begin
			wr(8'h4c, 8'(s));
			repeat (40) @(posedge pixClk);
			chk(pixBus, {24{s[2]}});
			chk(pnlHsync, s[1]);
			chk(pnlVsync, s[0]);
			chk(pnlDe, 1'b0);
		end
		wr(8'h4c, 8'h03);
		mainRgb <= 24'($urandom);
		// Every output order code.
		for (int o = 0; o < 8; o++) begin
			wr(8'h48, 8'h40 | 8'(o));
			waitPix(2);
			chk(lastPix, perm(3'(o), mainRgb, 1'b0));
		end
		wr(8'h4c, 8'h07);
		waitPix(2);
		chk(lastPix, 24'hffffff);
		wr(8'h4c, 8'h03);
		wr(8'h48, 8'h40);
		win1 <= {24'($urandom), 1'b1};
		win2 <= {24'($urandom), 1'b1};
		// Overlay enables and stacking, all four combinations.
		for (int k = 0; k < 4; k++) begin
			wr(8'h40, {2'(k), 6'h04});
			waitPix(2);
			chk(lastPix, k[1] ? win1.rgb : (k[0] ? win2.rgb : mainRgb));
		end
		// Reverse scan hides both overlays and the cursor.
		wr(8'h48, 8'h48);
		waitPix(2);
		chk(lastPix, mainRgb);
		chk(cursorEn, 1'b0);
		// First active line after the frame sync is the last line.
		@(posedge pnlVsync);
		@(posedge pnlDe);
		@(posedge pixClk);
		chk(scanLine, 8'(`LWDC_V_ACT - 8'd1));
		wr(8'h48, 8'h40);
		waitPix(2);
		chk(cursorEn, 1'b1);
		@(posedge pnlVsync);
		@(posedge pnlDe);
		@(posedge pixClk);
		chk(scanLine, 8'h00);
		// Colour bar: every component fully off or fully on.
		mainRgb <= 24'h123456;
		wr(8'h48, 8'h60);
		waitPix(3);
		chk((lastPix[23:16] == 8'h00 || lastPix[23:16] == 8'hff) &&
			(lastPix[15:8] == 8'h00 || lastPix[15:8] == 8'hff) &&
			(lastPix[7:0] == 8'h00 || lastPix[7:0] == 8'hff), 1'b1);
		wr(8'h48, 8'h00);
		wr(8'h48, 8'h40);
		// Sync mode against data-enable-only mode.
		for (int m = 0; m < 2; m++) begin
			wr(8'h40, 8'h84 | 8'(m));
			repeat (30) @(posedge pixClk);
			h0 = hsFalls;
			c0 = pixCnt;
			v0 = vsFalls;
			repeat (2000) @(posedge pixClk);
			chk(hsFalls == h0, m[0]);
			chk(vsFalls == v0, m[0]);
			chk(pixCnt > c0, 1'b1);
		end
		// Sampling edge follows the inversion bit.
		jitter <= 1'b1;
		for (int e = 0; e < 2; e++) begin
			sampleFall <= e[0];
			wr(8'h48, {e[0], 7'h40});
			waitPix(4);
			h0 = holdErr;
			waitPix(8);
			chk(holdErr, h0);
		end
		jitter <= 1'b0;
		stop_test;
	end

	// Watchdog against a hang.
	initial begin
		#600000;
		errors++;
		stop_test;
	end
endmodule // testbench
